// ===== pfs_map.vh
// Summary of operation
// - single chip mode forces every lower port D pin to general I/O.
// - in extended mode with program memory invalid every lower port D pin is a data bus bit.
// - port E direction is 16 bits; 1 makes an output, 0 an input.
// - direction bits act only for general I/O or timer capture/compare functions.
// - port E direction clears to zero on external power-on reset.
// - port E direction holds through manual, watchdog reset, standby and sleep.
// - upper function select steers port E pins 15..8, lower steers 7..0.
// - address-hold and DMA acknowledge selections are ignored in single chip mode.
// - both port E function selects clear on power-on reset, hold otherwise.
// - lower port D select clears only on power-on reset, holds otherwise.
// - lower port D bits act only in extended mode with program memory enabled.
`ifndef PFS_MAP_VH
`define PFS_MAP_VH
`define PFS_OFS_PD_LOW 4'h0
`define PFS_OFS_PE_DIR 4'h4
`define PFS_OFS_PE_UP 4'h8
`define PFS_OFS_PE_LOW 4'hC
`define PFS_RST_VAL 16'h0000
`define PFS_PD_MASK 16'h7FFF
`define PFS_PE_UP_MASK 16'hFD55
`define PFS_PE_LOW_MASK 16'h55FF
`define PFS_RESP_OKAY 2'b00
`define PFS_RESP_SLVERR 2'b10
`endif

// ===== pfs_sync2.v
`default_nettype none
// two-flop synchroniser for mode pins; first stage read only by the second
module pfs_sync2 (
  input wire aclk,
  input wire aresetn,
  input wire din,
  output reg dout
);
  reg meta_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== pfs_pe_pin.v
`default_nettype none
// one port E pin: decode its 2-bit function field and gate the direction bit
module pfs_pe_pin (
  input wire [1:0] func,
  input wire two_bit,
  input wire has_ack,
  input wire single_chip,
  input wire dir_bit,
  output wire is_gpio,
  output wire is_timer,
  output wire oe
);
  // ack/hold codes are dropped in single chip mode and the pin falls back to gpio
  wire ack_sel = two_bit & has_ack & func[1] & single_chip;
  assign is_gpio = two_bit ? ((func == 2'b00) | ack_sel) : ~func[0];
  assign is_timer = two_bit ? (func == 2'b01) : func[0];
  // direction only counts for gpio or timer pins
  assign oe = (is_gpio | is_timer) & dir_bit;
endmodule
`default_nettype wire

// ===== pfs_top.v
`include "pfs_map.vh"
`default_nettype none
module pfs_top (
  // clock and reset (reset stands for external power-on reset only)
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // mode pins from outside
  input wire single_chip_mode,
  input wire rom_invalid,
  // pin mux results
  output reg [14:0] portd_data_bus_sel,
  output reg [15:0] porte_gpio_sel,
  output reg [15:0] porte_timer_sel,
  output reg [15:0] porte_output_enable
);
  reg [15:0] port_d_low_function_select_q;
  reg [15:0] port_e_direction_q;
  reg [15:0] port_e_upper_function_select_q;
  reg [15:0] port_e_lower_function_select_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  wire single_chip_s;
  wire rom_invalid_s;

  // mode pins are asynchronous to aclk
  pfs_sync2 u_sync_sc (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(single_chip_mode),
    .dout(single_chip_s)
  );
  pfs_sync2 u_sync_rom (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(rom_invalid),
    .dout(rom_invalid_s)
  );

  // write channel: address and data taken in either order, one write in flight
  wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  // channel hand-offs and the alignment test used by both response and write
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_aligned = (awaddr_q[1:0] == 2'b00);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFS_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_aligned ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane merge; reserved bits masked so they always read zero
  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [15:0] mask;
    begin
      merge = old;
      if (strb[0]) merge[7:0] = data[7:0];
      if (strb[1]) merge[15:8] = data[15:8];
      merge = merge & mask;
    end
  endfunction

  // one write strobe per register; misaligned or unmapped offsets write nothing
  // so a bad address can never corrupt a neighbouring register
  wire wr_ok = wr_go & aw_aligned;
  wire wr_pd = wr_ok & (awaddr_q == `PFS_OFS_PD_LOW);
  wire wr_dir = wr_ok & (awaddr_q == `PFS_OFS_PE_DIR);
  wire wr_up = wr_ok & (awaddr_q == `PFS_OFS_PE_UP);
  wire wr_low = wr_ok & (awaddr_q == `PFS_OFS_PE_LOW);

  // lower port D select; reset is power-on only, other resets never reach it
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_d_low_function_select_q <= `PFS_RST_VAL;
    end else if (wr_pd) begin
      port_d_low_function_select_q <= merge(port_d_low_function_select_q,
        wdata_q, wstrb_q, `PFS_PD_MASK);
    end
  end

  // port E direction; kept through every reset but power-on
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_e_direction_q <= `PFS_RST_VAL;
    end else if (wr_dir) begin
      port_e_direction_q <= merge(port_e_direction_q, wdata_q, wstrb_q,
        16'hFFFF);
    end
  end

  // upper port E function select, pins 15..8
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_e_upper_function_select_q <= `PFS_RST_VAL;
    end else if (wr_up) begin
      port_e_upper_function_select_q <= merge(port_e_upper_function_select_q,
        wdata_q, wstrb_q, `PFS_PE_UP_MASK);
    end
  end

  // lower port E function select, pins 7..0
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_e_lower_function_select_q <= `PFS_RST_VAL;
    end else if (wr_low) begin
      port_e_lower_function_select_q <= merge(port_e_lower_function_select_q,
        wdata_q, wstrb_q, `PFS_PE_LOW_MASK);
    end
  end

  // read data chosen from the live registers; misaligned offsets read zero
  // so software never sees a half-decoded word
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire ar_aligned = (s_axi_araddr[1:0] == 2'b00);
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    if (ar_aligned) begin
      case (s_axi_araddr)
        `PFS_OFS_PD_LOW: rdata_d = {16'h0000, port_d_low_function_select_q};
        `PFS_OFS_PE_DIR: rdata_d = {16'h0000, port_e_direction_q};
        `PFS_OFS_PE_UP: rdata_d = {16'h0000, port_e_upper_function_select_q};
        `PFS_OFS_PE_LOW: rdata_d = {16'h0000, port_e_lower_function_select_q};
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // read channel: one cycle to accept, answer the next
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PFS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ar_aligned ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
        s_axi_rdata <= rdata_d;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // port E function fields: upper register pins 15..8, lower register 7..0
  wire [31:0] pe_fields = {port_e_upper_function_select_q, port_e_lower_function_select_q};
  // pins with 2-bit fields: 15,14,13 and 3..0; ack-capable: 15,14,3,2,1,0
  localparam [15:0] TWO_BIT = 16'hE00F;
  localparam [15:0] HAS_ACK = 16'hC00F;
  wire [15:0] pe_gpio;
  wire [15:0] pe_timer;
  wire [15:0] pe_oe;
  // one slice per port E pin; the slice owns the function decode and gating
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pe
      pfs_pe_pin u_pin (
        .func(pe_fields[2*gi+1:2*gi]),
        .two_bit(TWO_BIT[gi]),
        .has_ack(HAS_ACK[gi]),
        .single_chip(single_chip_s),
        .dir_bit(port_e_direction_q[gi]),
        .is_gpio(pe_gpio[gi]),
        .is_timer(pe_timer[gi]),
        .oe(pe_oe[gi])
      );
    end
  endgenerate

  // operating mode as a one-hot code; single chip is tested first so it wins
  // over invalid program memory when both mode pins are high
  localparam [2:0] MODE_SINGLE = 3'b001;
  localparam [2:0] MODE_EXT_NOROM = 3'b010;
  localparam [2:0] MODE_EXT_ROM = 3'b100;
  reg [2:0] mode_d;
  always @* begin
    if (single_chip_s) begin
      mode_d = MODE_SINGLE;
    end else if (rom_invalid_s) begin
      mode_d = MODE_EXT_NOROM;
    end else begin
      mode_d = MODE_EXT_ROM;
    end
  end

  // port D: mode decides first, register bits only in rom-enabled extended mode
  reg [14:0] pd_sel_d;
  always @* begin
    case (mode_d)
      MODE_SINGLE: begin
        pd_sel_d = 15'h0000;
      end
      MODE_EXT_NOROM: begin
        pd_sel_d = 15'h7FFF;
      end
      MODE_EXT_ROM: begin
        pd_sel_d = port_d_low_function_select_q[14:0];
      end
      default: begin
        pd_sel_d = 15'h0000;
      end
    endcase
  end

  // pin outputs come from flops; one cycle behind registers and synced modes
  always @(posedge aclk) begin
    if (!aresetn) begin
      portd_data_bus_sel <= 15'h0000;
    end else begin
      portd_data_bus_sel <= pd_sel_d;
    end
  end

  // every port E pin is plain gpio until software picks another function
  always @(posedge aclk) begin
    if (!aresetn) begin
      porte_gpio_sel <= 16'hFFFF;
    end else begin
      porte_gpio_sel <= pe_gpio;
    end
  end

  // timer capture/compare selection per pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      porte_timer_sel <= 16'h0000;
    end else begin
      porte_timer_sel <= pe_timer;
    end
  end

  // output enable already gated by the function inside each pin slice
  always @(posedge aclk) begin
    if (!aresetn) begin
      porte_output_enable <= 16'h0000;
    end else begin
      porte_output_enable <= pe_oe;
    end
  end
endmodule
`default_nettype wire

// ===== pfs_top_sva.sv
`default_nettype none
module pfs_top_sva (
  // clock and reset
  input wire logic aclk, aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // mode pins and pin mux results
  input wire logic single_chip_mode, rom_invalid,
  input wire logic [14:0] portd_data_bus_sel,
  input wire logic [15:0] porte_gpio_sel, porte_timer_sel, porte_output_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data offered together, as the bench always does
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'b00;
  endsequence
  property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_ok; s_rd_taken |=> s_axi_rvalid && s_axi_rresp == 2'b00; endproperty
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  // mode pins pass two sync flops and the output flop: four samples settle it
  property p_single; single_chip_mode [*4] |-> portd_data_bus_sel == 15'h0000; endproperty
  property p_rom;
    (rom_invalid && !single_chip_mode) [*4] |-> portd_data_bus_sel == 15'h7FFF;
  endproperty
  property p_oe_gate;
    (porte_output_enable & ~(porte_gpio_sel | porte_timer_sel)) == 16'h0000;
  endproperty
  property p_por;
    $rose(aresetn) |-> portd_data_bus_sel == 15'h0000 && porte_output_enable == 16'h0000
      && porte_gpio_sel == 16'hFFFF && porte_timer_sel == 16'h0000;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_rd_ok: assert property (p_rd_ok) else $error("aligned read not answered");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
  a_single: assert property (p_single) else $error("data bus used in single chip");
  a_rom: assert property (p_rom) else $error("data bus not forced");
  a_oe_gate: assert property (p_oe_gate) else $error("direction on other function");
  a_por: assert property (p_por) else $error("bad state after reset");
endmodule
bind pfs_top pfs_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_araddr, .s_axi_rresp, .s_axi_rdata,
  .single_chip_mode, .rom_invalid, .portd_data_bus_sel, .porte_gpio_sel, .porte_timer_sel,
  .porte_output_enable);
`default_nettype wire

// ===== tb_pfs_top.sv
`include "pfs_map.vh"
`default_nettype none
module tb_pfs_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, single_chip_mode = 0, rom_invalid = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0, a;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'h00011B49;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] portd_data_bus_sel;
  logic [15:0] porte_gpio_sel, porte_timer_sel, porte_output_enable;
  int n_fail = 0, n_tests = 0, i;
  pfs_top u_dut (.*);
  initial forever #25 aclk = ~aclk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reserved bits read back as zero
  function logic [15:0] msk(input logic [3:0] ad);
    case (ad)
      `PFS_OFS_PD_LOW: msk = `PFS_PD_MASK;
      `PFS_OFS_PE_UP: msk = `PFS_PE_UP_MASK;
      `PFS_OFS_PE_LOW: msk = `PFS_PE_LOW_MASK;
      default: msk = 16'hFFFF;
    endcase
  endfunction
  // single chip wins over invalid program memory
  function logic [14:0] exp_pd(input logic [14:0] v, input logic sc, ri);
    exp_pd = sc ? 15'h0000 : (ri ? 15'h7FFF : v);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ready held back at random to exercise response stalls
  task automatic wr(input logic [3:0] ad, input logic [31:0] dd, input logic [3:0] s,
      input logic [1:0] er);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dd;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (rnd() > 32'h7FFFFFFF) s_axi_bready <= 1'b1;
    end
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (rnd() > 32'h7FFFFFFF) s_axi_rready <= 1'b1;
    end
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // mode pins need sync plus output flop before the pins settle
  task automatic mode(input logic sc, ri);
    single_chip_mode <= sc;
    rom_invalid <= ri;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(porte_output_enable, 16'h0000);
    chk(porte_gpio_sel, 16'hFFFF);
    for (i = 0; i < 4; i++) rd(4'(i * 4), 0, `PFS_RESP_OKAY);
    for (i = 0; i < 40; i++) begin
      d = rnd();
      a = {d[17:16], 2'b00};
      wr(a, d, 4'hF, `PFS_RESP_OKAY);
      rd(a, {16'h0000, d[15:0] & msk(a)}, `PFS_RESP_OKAY);
      if (a == `PFS_OFS_PD_LOW) chk(portd_data_bus_sel, d[14:0]);
    end
    wr(`PFS_OFS_PD_LOW, 0, 4'hF, `PFS_RESP_OKAY);
    wr(`PFS_OFS_PD_LOW, 32'hFFFF, 4'h2, `PFS_RESP_OKAY);
    rd(`PFS_OFS_PD_LOW, 32'h7F00, `PFS_RESP_OKAY);
    wr(4'h5, 32'hFFFF, 4'hF, `PFS_RESP_SLVERR);
    rd(4'h6, 0, `PFS_RESP_SLVERR);
    wr(`PFS_OFS_PD_LOW, 32'h5A5A, 4'hF, `PFS_RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      mode(i[0], i[1]);
      chk(portd_data_bus_sel, exp_pd(15'h5A5A, i[0], i[1]));
    end
    mode(0, 0);
    wr(`PFS_OFS_PE_DIR, 32'hFFFF, 4'hF, `PFS_RESP_OKAY);
    wr(`PFS_OFS_PE_LOW, 0, 4'hF, `PFS_RESP_OKAY);
    wr(`PFS_OFS_PE_UP, 0, 4'hF, `PFS_RESP_OKAY);
    chk(porte_output_enable, 16'hFFFF);
    wr(`PFS_OFS_PE_UP, 32'h2C00, 4'hF, `PFS_RESP_OKAY);
    chk(porte_output_enable, 16'h9FFF);
    chk(porte_gpio_sel, 16'h9FFF);
    mode(1, 0);
    chk(porte_output_enable, 16'hDFFF);
    chk(porte_gpio_sel, 16'hDFFF);
    mode(0, 0);
    wr(`PFS_OFS_PE_UP, 32'h0400, 4'hF, `PFS_RESP_OKAY);
    wr(`PFS_OFS_PE_LOW, 32'h0001, 4'hF, `PFS_RESP_OKAY);
    chk(porte_timer_sel, 16'h2001);
    chk(porte_output_enable, 16'hFFFF);
    report_and_stop();
  end
  // a hung handshake ends the run well past the expected length
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
